// ==== include/adcci_params.svh ====
`ifndef ADCCI_PARAMS_SVH
`define ADCCI_PARAMS_SVH
// ==========================================================
// Register addresses
`define ADCCI_ADDR_POWER 16'hFF01
`define ADCCI_ADDR_CTRL 16'hFFD0
`define ADCCI_ADDR_PINEN 16'hFFD1
`define ADCCI_ADDR_RES_LO 16'hFFD2
`define ADCCI_ADDR_RES_HI 16'hFFD3
`define ADCCI_ADDR_IRQEN 16'hFFE7
`define ADCCI_ADDR_IRQFLG 16'hFFF7
// ==========================================================
// Field positions
`define ADCCI_BIT_BOOSTER 0
`define ADCCI_BIT_REGSEL 2
`define ADCCI_BIT_CONVPWR 3
`define ADCCI_BIT_START 3
`define ADCCI_BIT_CLKSEL 2
`define ADCCI_BIT_IRQ 0
// ==========================================================
// Reset values and constants
`define ADCCI_RST_NIBBLE 4'h0
`define ADCCI_IRQ_VECTOR 12'h10E
// Conversion time in ns at a 1 MHz conversion clock
`define ADCCI_CONV_TIME_NS 21000
`define ADCCI_CLK_PERIOD_NS 40
// Least time, rounded up
`define ADCCI_CONV_CYCLES \
   ((`ADCCI_CONV_TIME_NS + `ADCCI_CLK_PERIOD_NS - 1) / `ADCCI_CLK_PERIOD_NS)
`endif

// ==== include/adcci_pkg.sv ====
package adcci_pkg;
   // ==========================================================
   // Types
   typedef enum logic [1:0] {
      ADCCI_IDLE = 2'b00,
      ADCCI_CONV = 2'b01,
      ADCCI_STORE = 2'b11
   } adcci_state_t;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [15:0] addr;
      logic [3:0] wdata;
   } adcci_bus_t;

   typedef struct packed {
      logic conv_power_select;
      logic regulator_power_select;
      logic booster_on;
      logic conv_clock_select;
      logic [1:0] channel_select;
      logic [3:0] analog_pin_enable;
   } adcci_cfg_t;
endpackage : adcci_pkg

// ==== design/adcci_irq_flag.sv ====
`timescale 1ns/1ps
module adcci_irq_flag
   import adcci_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic set_i,
   input wire logic clr_i,
   input wire logic enable_i,
   output logic flag_o,
   output logic irq_o
);
   logic flag_q;

   // ==========================================================
   // Sticky flag; a set in the clear cycle wins
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         flag_q <= 1'b0;
      end else if (set_i) begin
         flag_q <= 1'b1;
      end else if (clr_i) begin
         flag_q <= 1'b0;
      end
   end

   assign flag_o = flag_q;
   // Request follows the flag while unmasked
   assign irq_o = flag_q & enable_i;

   a_flag_sets: assert property (@(posedge clk_i) disable iff (rst_i)
      set_i |=> flag_q) else $error("flag not set");
   a_flag_holds: assert property (@(posedge clk_i) disable iff (rst_i)
      flag_q && !clr_i |=> flag_q) else $error("flag lost");
endmodule : adcci_irq_flag

// ==== design/adcci_sar.sv ====
`timescale 1ns/1ps
`include "adcci_params.svh"
module adcci_sar
   import adcci_pkg::*;
#(
   parameter int CONV_CYCLES = `ADCCI_CONV_CYCLES
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic start_i,
   input wire logic [7:0] sample_i,
   output logic busy_o,
   output logic done_o,
   output logic [7:0] result_o
);
   localparam int CW = $clog2(CONV_CYCLES + 1);
   adcci_state_t state_q;
   logic [CW-1:0] cnt_q;
   logic [7:0] result_q;

   // ==========================================================
   // Sequencer; a start while busy is dropped
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_q <= ADCCI_IDLE;
         cnt_q <= '0;
      end else begin
         case (state_q)
            ADCCI_IDLE: begin
               if (start_i) begin
                  state_q <= ADCCI_CONV;
                  cnt_q <= CW'(CONV_CYCLES - 1);
               end
            end
            ADCCI_CONV: begin
               if (cnt_q == '0) begin
                  state_q <= ADCCI_STORE;
               end else begin
                  cnt_q <= cnt_q - 1'b1;
               end
            end
            ADCCI_STORE: begin
               state_q <= ADCCI_IDLE;
            end
            default: begin
               state_q <= ADCCI_IDLE;
            end
         endcase
      end
   end

   // Result word only changes on completion; undefined before first
   always_ff @(posedge clk_i) begin
      if (state_q == ADCCI_STORE) begin
         result_q <= sample_i;
      end
   end

   assign busy_o = (state_q != ADCCI_IDLE);
   assign done_o = (state_q == ADCCI_STORE);
   assign result_o = result_q;

   a_done_spacing: assert property (@(posedge clk_i) disable iff (rst_i)
      done_o |=> !done_o [*8]) else $error("double done");
   a_conv_ends: assert property (@(posedge clk_i) disable iff (rst_i)
      state_q == ADCCI_IDLE && start_i |-> ##[1:600] done_o)
      else $error("conversion never ends");
   c_conv_run: cover property (@(posedge clk_i) start_i && !busy_o);
   c_busy_start: cover property (@(posedge clk_i) start_i && busy_o);
endmodule : adcci_sar

// ==== design/adcci_top.sv ====
`timescale 1ns/1ps
`include "adcci_params.svh"
module adcci_top
   import adcci_pkg::*;
#(
   parameter int CONV_CYCLES = `ADCCI_CONV_CYCLES
) (
   input wire logic CLK_SYS_I,
   input wire logic RESET_I,
   input wire logic BUS_WR_I,
   input wire logic BUS_RD_I,
   input wire logic [15:0] BUS_ADDR_I,
   input wire logic [3:0] BUS_WDATA_I,
   input wire logic [7:0] ANALOG_SAMPLE_I,
   output logic [3:0] BUS_RDATA_O,
   output logic IRQ_O,
   output logic [11:0] IRQ_VECTOR_O,
   output logic CONV_BUSY_O,
   output logic [3:0] ANALOG_PIN_ENABLE_O,
   output logic CONV_CLOCK_SELECT_O,
   output logic [1:0] CHANNEL_SELECT_O,
   output logic CONV_POWER_SELECT_O,
   output logic REGULATOR_POWER_SELECT_O,
   output logic BOOSTER_ON_O
);
   adcci_bus_t bus;
   adcci_cfg_t cfg_q;
   logic irq_enable_q;
   logic [3:0] rdata_q;
   logic start_wr;
   logic clr_wr;
   logic busy;
   logic done;
   logic flag;
   logic irq;
   logic [7:0] result;

   // ==========================================================
   // Bus capture
   assign bus = '{wr: BUS_WR_I, rd: BUS_RD_I, addr: BUS_ADDR_I,
                  wdata: BUS_WDATA_I};

   function automatic logic hit(input logic [15:0] a,
                                input logic [15:0] ref_a);
      hit = (a == ref_a);
   endfunction : hit

   // Strobes; start only as a write of one
   assign start_wr = bus.wr && hit(bus.addr, `ADCCI_ADDR_CTRL) &&
                     bus.wdata[`ADCCI_BIT_START];
   assign clr_wr = bus.wr && hit(bus.addr, `ADCCI_ADDR_IRQFLG) &&
                   bus.wdata[`ADCCI_BIT_IRQ];

   // ==========================================================
   // Configuration registers
   // Settings stay writable mid-conversion; software must avoid that
   always_ff @(posedge CLK_SYS_I) begin
      if (RESET_I) begin
         cfg_q <= '0;
      end else if (bus.wr) begin
         if (hit(bus.addr, `ADCCI_ADDR_POWER)) begin
            cfg_q.conv_power_select <= bus.wdata[`ADCCI_BIT_CONVPWR];
            cfg_q.regulator_power_select <=
               bus.wdata[`ADCCI_BIT_REGSEL];
            cfg_q.booster_on <= bus.wdata[`ADCCI_BIT_BOOSTER];
         end
         if (hit(bus.addr, `ADCCI_ADDR_CTRL)) begin
            cfg_q.conv_clock_select <= bus.wdata[`ADCCI_BIT_CLKSEL];
            cfg_q.channel_select <= bus.wdata[1:0];
         end
         if (hit(bus.addr, `ADCCI_ADDR_PINEN)) begin
            cfg_q.analog_pin_enable <= bus.wdata;
         end
      end
   end

   // Interrupt mask
   always_ff @(posedge CLK_SYS_I) begin
      if (RESET_I) begin
         irq_enable_q <= 1'b0;
      end else if (bus.wr && hit(bus.addr, `ADCCI_ADDR_IRQEN)) begin
         irq_enable_q <= bus.wdata[`ADCCI_BIT_IRQ];
      end
   end

   // ==========================================================
   // Read data, registered; unused bits zero, unmapped reads zero
   always_ff @(posedge CLK_SYS_I) begin
      if (RESET_I) begin
         rdata_q <= `ADCCI_RST_NIBBLE;
      end else if (bus.rd) begin
         case (bus.addr)
            `ADCCI_ADDR_POWER: begin
               rdata_q <= {cfg_q.conv_power_select,
                           cfg_q.regulator_power_select, 1'b0,
                           cfg_q.booster_on};
            end
            `ADCCI_ADDR_CTRL: begin
               // Start bit reads zero, its value has no meaning
               rdata_q <= {1'b0, cfg_q.conv_clock_select,
                           cfg_q.channel_select};
            end
            `ADCCI_ADDR_PINEN: begin
               rdata_q <= cfg_q.analog_pin_enable;
            end
            `ADCCI_ADDR_RES_LO: begin
               rdata_q <= result[3:0];
            end
            `ADCCI_ADDR_RES_HI: begin
               rdata_q <= result[7:4];
            end
            `ADCCI_ADDR_IRQEN: begin
               rdata_q <= {3'b000, irq_enable_q};
            end
            `ADCCI_ADDR_IRQFLG: begin
               rdata_q <= {3'b000, flag};
            end
            default: begin
               rdata_q <= 4'h0;
            end
         endcase
      end
   end

   // ==========================================================
   // Conversion sequencer and flag
   adcci_sar #(
      .CONV_CYCLES(CONV_CYCLES)
   ) u_sar (
      .clk_i(CLK_SYS_I),
      .rst_i(RESET_I),
      .start_i(start_wr),
      .sample_i(ANALOG_SAMPLE_I),
      .busy_o(busy),
      .done_o(done),
      .result_o(result)
   );

   adcci_irq_flag u_flag (
      .clk_i(CLK_SYS_I),
      .rst_i(RESET_I),
      .set_i(done),
      .clr_i(clr_wr),
      .enable_i(irq_enable_q),
      .flag_o(flag),
      .irq_o(irq)
   );

   // ==========================================================
   // Outputs
   assign BUS_RDATA_O = rdata_q;
   assign IRQ_O = irq;
   assign IRQ_VECTOR_O = `ADCCI_IRQ_VECTOR;
   assign CONV_BUSY_O = busy;
   assign ANALOG_PIN_ENABLE_O = cfg_q.analog_pin_enable;
   assign CONV_CLOCK_SELECT_O = cfg_q.conv_clock_select;
   assign CHANNEL_SELECT_O = cfg_q.channel_select;
   assign CONV_POWER_SELECT_O = cfg_q.conv_power_select;
   assign REGULATOR_POWER_SELECT_O = cfg_q.regulator_power_select;
   assign BOOSTER_ON_O = cfg_q.booster_on;

   // ==========================================================
   // Checks
   a_irq_masked: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
      !irq_enable_q |-> !IRQ_O) else $error("masked irq raised");
   a_flag_after_store: assert property (@(posedge CLK_SYS_I)
      disable iff (RESET_I) done |=> flag && result == $past(ANALOG_SAMPLE_I))
      else $error("flag or result wrong");
   a_clear_works: assert property (@(posedge CLK_SYS_I)
      disable iff (RESET_I) clr_wr && !done |=> !flag)
      else $error("flag not cleared");
   a_zero_keeps: assert property (@(posedge CLK_SYS_I)
      disable iff (RESET_I)
      bus.wr && hit(bus.addr, `ADCCI_ADDR_IRQFLG) && !bus.wdata[0] && flag
      |=> flag) else $error("zero write cleared flag");
   a_busy_ignore: assert property (@(posedge CLK_SYS_I)
      disable iff (RESET_I) busy && !done && start_wr |=>
      $stable(result) || done)
      else $error("restart disturbed result");
   a_pin_write: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
      bus.wr && hit(bus.addr, `ADCCI_ADDR_PINEN)
      |=> ANALOG_PIN_ENABLE_O == $past(bus.wdata))
      else $error("pin enable not written");
   a_unused_zero: assert property (@(posedge CLK_SYS_I)
      disable iff (RESET_I) $past(bus.rd) &&
      $past(bus.addr) == `ADCCI_ADDR_IRQEN |-> BUS_RDATA_O[3:1] == 3'b000)
      else $error("unused bits nonzero");
   a_vector_fixed: assert property (@(posedge CLK_SYS_I)
      IRQ_VECTOR_O == 12'h10E) else $error("bad vector");
   c_irq_raised: cover property (@(posedge CLK_SYS_I) $rose(IRQ_O));
   c_masked_flag: cover property (@(posedge CLK_SYS_I)
      flag && !irq_enable_q);
   c_set_clear: cover property (@(posedge CLK_SYS_I) done && clr_wr);
endmodule : adcci_top

// ==== tb/adcci_cpu_model.sv ====
`timescale 1ns/1ps
`include "adcci_params.svh"
module adcci_cpu_model
   import adcci_pkg::*;
#(
   parameter int SUPPLY_MV = 3000,
   parameter int SETTLE_CYCLES = 16
) (
   input wire logic clk_i,
   input wire logic [3:0] rdata_i,
   input wire logic irq_i,
   output adcci_bus_t bus_o
);
   // ==========================================================
   // Bus access
   initial begin
      bus_o = '0;
   end

   // Strobe raised at a falling edge and dropped at the next one
   task automatic wr_reg(input logic [15:0] a, input logic [3:0] d);
      @(negedge clk_i);
      bus_o.wr = 1'b1;
      bus_o.addr = a;
      bus_o.wdata = d;
      @(negedge clk_i);
      bus_o.wr = 1'b0;
      bus_o.addr = ~a; // Released lines must not keep the last value
      bus_o.wdata = ~d;
   endtask : wr_reg

   // Read data is registered, so it is taken one edge later
   task automatic rd_reg(input logic [15:0] a, output logic [3:0] d);
      @(negedge clk_i);
      bus_o.rd = 1'b1;
      bus_o.addr = a;
      @(negedge clk_i);
      bus_o.rd = 1'b0;
      bus_o.addr = ~a;
      d = rdata_i;
   endtask : rd_reg

   // ==========================================================
   // Software sequences
   // Low supply needs the boosted rail, which must settle first
   task automatic start_conv(input logic [1:0] ch);
      logic [3:0] ctl;
      if (SUPPLY_MV <= 1600) begin
         wr_reg(`ADCCI_ADDR_POWER, 4'h9);
         repeat (SETTLE_CYCLES) @(negedge clk_i);
      end
      wr_reg(`ADCCI_ADDR_PINEN, 4'h1 << ch);
      ctl = {1'b0, SUPPLY_MV >= 2200, ch};
      wr_reg(`ADCCI_ADDR_CTRL, ctl);
      wr_reg(`ADCCI_ADDR_CTRL, ctl | 4'h8);
   endtask : start_conv

   // Flag cleared before returning, or the request would repeat
   task automatic service_irq();
      logic [3:0] f;
      if (irq_i === 1'b1) begin
         rd_reg(`ADCCI_ADDR_IRQFLG, f);
         wr_reg(`ADCCI_ADDR_IRQFLG, 4'h1);
      end
   endtask : service_irq
endmodule : adcci_cpu_model

// ==== tb/adc_control_and_interrupt_test.sv ====
`timescale 1ns/1ps
`include "adcci_params.svh"
module adc_control_and_interrupt_test
   import adcci_pkg::*;
;
   localparam int CONV_N = 4;
   logic clk_sys;
   logic reset;
   logic [7:0] sample;
   adcci_bus_t bus;
   logic [3:0] rdata;
   logic irq;
   logic [11:0] vec;
   logic busy;
   logic [3:0] pin_en;
   logic clk_sel;
   logic [1:0] ch_sel;
   logic pwr_sel;
   logic reg_sel;
   logic boost;
   int error_cnt = 0;
   int n_compared = 0;
   int n;
   logic [15:0] addrs [6];

   adcci_top #(.CONV_CYCLES(CONV_N)) i_adcci_top (
      .CLK_SYS_I(clk_sys), .RESET_I(reset), .BUS_WR_I(bus.wr),
      .BUS_RD_I(bus.rd), .BUS_ADDR_I(bus.addr),
      .BUS_WDATA_I(bus.wdata), .ANALOG_SAMPLE_I(sample),
      .BUS_RDATA_O(rdata), .IRQ_O(irq), .IRQ_VECTOR_O(vec),
      .CONV_BUSY_O(busy), .ANALOG_PIN_ENABLE_O(pin_en),
      .CONV_CLOCK_SELECT_O(clk_sel), .CHANNEL_SELECT_O(ch_sel),
      .CONV_POWER_SELECT_O(pwr_sel),
      .REGULATOR_POWER_SELECT_O(reg_sel), .BOOSTER_ON_O(boost)
   );

   adcci_cpu_model i_adcci_cpu_model (
      .clk_i(clk_sys), .rdata_i(rdata), .irq_i(irq), .bus_o(bus)
   );

   // ==========================================================
   // Clock and watchdog
   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end

   // Whole run is about 150 cycles; allow ample margin
   initial begin
      #(40 * 5000);
      error_cnt++;
      $display("Error at %0t: watchdog expired", $time);
      finish_test();
   end

   // ==========================================================
   // Helpers
   task automatic check(input logic [11:0] seen, input logic [11:0] exp);
      n_compared++;
      if (seen !== exp) begin
         error_cnt++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic w(input logic [15:0] a, input logic [3:0] d);
      i_adcci_cpu_model.wr_reg(a, d);
   endtask : w

   task automatic rchk(input logic [15:0] a, input logic [3:0] exp);
      logic [3:0] d;
      i_adcci_cpu_model.rd_reg(a, d);
      check({8'h00, d}, {8'h00, exp});
   endtask : rchk

   // Bounded wait for the converter to go idle, counting cycles
   task automatic wait_done();
      n = 0;
      while (busy === 1'b1 && n < 100) begin
         @(negedge clk_sys);
         n++;
      end
   endtask : wait_done

   task automatic finish_test();
      $display("Compared %0d, errors %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : finish_test

   // ==========================================================
   // Main sequence
   initial begin
      reset = 1'b1;
      sample = 8'hA5;
      addrs = '{`ADCCI_ADDR_POWER, `ADCCI_ADDR_CTRL, `ADCCI_ADDR_PINEN,
                `ADCCI_ADDR_IRQEN, `ADCCI_ADDR_IRQFLG, 16'h0123};
      repeat (8) @(negedge clk_sys);
      reset = 1'b0;
      check(vec, 12'h10E);
      check({pin_en, clk_sel, ch_sel, pwr_sel, reg_sel, boost, irq, busy},
            12'h000);
      foreach (addrs[i]) rchk(addrs[i], 4'h0);
      w(`ADCCI_ADDR_POWER, 4'hF);
      rchk(`ADCCI_ADDR_POWER, 4'hD);
      check({pwr_sel, reg_sel, boost}, 3'b111);
      for (int i = 0; i < 4; i++) begin
         w(`ADCCI_ADDR_PINEN, 4'h1 << i);
         rchk(`ADCCI_ADDR_PINEN, 4'h1 << i);
         check(pin_en, 4'h1 << i);
      end
      // Every clock and channel code, start bit left at zero
      for (int i = 0; i < 8; i++) begin
         w(`ADCCI_ADDR_CTRL, i[3:0]);
         rchk(`ADCCI_ADDR_CTRL, i[3:0]);
         check({busy, clk_sel, ch_sel}, i[2:0]);
      end
      w(`ADCCI_ADDR_IRQEN, 4'hF);
      rchk(`ADCCI_ADDR_IRQEN, 4'h1);
      w(`ADCCI_ADDR_IRQEN, 4'h0);
      w(16'h0123, 4'hF);
      rchk(16'h0123, 4'h0);
      // Masked conversion with a second start while busy
      i_adcci_cpu_model.start_conv(2'd1);
      check({busy, ch_sel}, 3'b101);
      w(`ADCCI_ADDR_CTRL, 4'hD);
      wait_done();
      check(n < CONV_N, 1'b1);
      rchk(`ADCCI_ADDR_IRQFLG, 4'h1);
      check(irq, 1'b0);
      rchk(`ADCCI_ADDR_RES_LO, 4'h5);
      rchk(`ADCCI_ADDR_RES_HI, 4'hA);
      w(`ADCCI_ADDR_RES_LO, 4'h0);
      rchk(`ADCCI_ADDR_RES_LO, 4'h5);
      w(`ADCCI_ADDR_IRQFLG, 4'h0);
      rchk(`ADCCI_ADDR_IRQFLG, 4'h1);
      w(`ADCCI_ADDR_IRQEN, 4'h1);
      check(irq, 1'b1);
      w(`ADCCI_ADDR_IRQFLG, 4'h1);
      check(irq, 1'b0);
      repeat (20) @(negedge clk_sys);
      rchk(`ADCCI_ADDR_IRQFLG, 4'h0);
      // Unmasked conversion serviced by the CPU model
      sample = 8'h3C;
      i_adcci_cpu_model.start_conv(2'd3);
      wait_done();
      check(n, CONV_N + 1);
      @(negedge clk_sys);
      check(irq, 1'b1);
      rchk(`ADCCI_ADDR_RES_LO, 4'hC);
      rchk(`ADCCI_ADDR_RES_HI, 4'h3);
      i_adcci_cpu_model.service_irq();
      check(irq, 1'b0);
      finish_test();
   end
endmodule : adc_control_and_interrupt_test
